//--- hdl/pllcc_pkg.sv
// Purpose: Shared constants for the PLL clock control block
// Assumes: One 40 MHz clock pclk, asynchronous active-low reset presetn
// Notes: All dividers and clocks are modelled as enables on pclk
package pllcc_pkg;
   localparam int unsigned PLLCC_NUM_OUT = 4;           // Clock outputs per PLL
   localparam logic [5:0] PLLCC_REFDIV_MIN = 6'h01;     // Smallest reference divide
   localparam logic [5:0] PLLCC_REFDIV_MAX = 6'h3f;     // Largest reference divide
   localparam logic [11:0] PLLCC_FBINT_MIN = 12'h008;   // Integer mode lower range start
   localparam logic [11:0] PLLCC_FBINT_GAP_HI = 12'h00a; // Integer mode lower range end
   localparam logic [11:0] PLLCC_FBINT_UP_MIN = 12'h00c; // Integer mode upper range start
   localparam logic [11:0] PLLCC_FBINT_MAX = 12'hfff;   // Integer mode upper range end
   localparam logic [11:0] PLLCC_FBFRAC_MIN = 12'h014;  // Fractional integer part min
   localparam logic [11:0] PLLCC_FBFRAC_MAX = 12'h1f4;  // Fractional integer part max
   localparam int unsigned PLLCC_FEEDBACK_FRACTION_W = 24;           // Fraction resolution
   localparam logic [3:0] PLLCC_LOCKDLY_DEF = 4'h8;     // Lock delay exponent default 2^8
   localparam logic [3:0] PLLCC_LOCKDLY_MIN = 4'h1;     // 2 cycles
   localparam logic [3:0] PLLCC_LOCKDLY_MAX = 4'hf;     // 32768 cycles
   localparam logic [7:0] PLLCC_OUTDIV_RST = 8'h01;     // Output divider reset value
   localparam logic [3:0] PLLCC_ALIGN_WIN = 4'hf;       // 16 VCO cycles alignment window
   localparam logic [3:0] PLLCC_LOCK_PHASES = 4'h4;     // Freq then phase lock settle cycles
   localparam logic [7:0] PLLCC_A_CTRL = 8'h00;         // Control register offset
   localparam logic [7:0] PLLCC_A_DIV = 8'h04;          // Divider register offset
   localparam logic [7:0] PLLCC_A_FEEDBACK_FRACTION = 8'h08;         // Fraction register offset
   localparam logic [7:0] PLLCC_A_STAT = 8'h0c;         // Status register offset
endpackage

//--- hdl/pllcc_if.sv
// Purpose: Carrier joining the PLL end and the fabric user end
// Assumes: Both ends clocked by pclk
// Notes: No clocking block; testbench joins the ends here
`timescale 1ns/100ps
`default_nettype none
interface pllcc_if;
   import pllcc_pkg::*;
   logic ref_sel;                        // 1 selects backup reference
   logic [5:0] ref_div;                  // Reference divide value
   logic [11:0] feedback_integer_part;   // Feedback divide integer part
   logic [23:0] feedback_fraction_value; // Feedback fraction
   logic feedback_fraction_mode;                      // Fractional feedback mode
   logic ext_fb_mode;                    // External feedback mode
   logic cascade_34;                     // Cascade third and fourth dividers
   logic [3:0] lock_delay_exp;           // Lock delay as power of two
   logic [7:0] out_div [PLLCC_NUM_OUT];  // Per-output divide value
   logic pll_sleep_n;                    // Active-low power-down
   logic [3:0] out_en;                   // Per-output enables
   logic ref_divider_sync_en;            // Sync start of reference dividers
   logic ref_divider_reg_en;             // Register divider enable
   logic ref_clk_primary_ok;             // Primary reference running
   logic ref_clk_backup_ok;              // Backup reference running
   logic feedback_clock_in;              // External feedback clock level
   logic [3:0] clk_out;                  // PLL clock outputs
   logic lock;                           // Lock indicator
   logic cfg_err;                        // Divider setting out of range
   modport pll (input ref_sel, ref_div, feedback_integer_part, feedback_fraction_value,
      feedback_fraction_mode, ext_fb_mode, cascade_34, lock_delay_exp, out_div, pll_sleep_n, out_en,
      ref_divider_sync_en, ref_divider_reg_en, ref_clk_primary_ok, ref_clk_backup_ok,
      feedback_clock_in, output clk_out, lock, cfg_err);
   modport fabric (output ref_sel, ref_div, feedback_integer_part, feedback_fraction_value,
      feedback_fraction_mode, ext_fb_mode, cascade_34, lock_delay_exp, out_div, pll_sleep_n, out_en,
      ref_divider_sync_en, ref_divider_reg_en, ref_clk_primary_ok, ref_clk_backup_ok,
      feedback_clock_in, input clk_out, lock, cfg_err);
endinterface
`default_nettype wire

//--- hdl/pllcc_pll.sv
// Purpose: Digital control model of one PLL: reference, dividers, lock, outputs
// Assumes: Clocks are enable pulses on pclk; the far end keeps its own duties
// Notes: Summary of operation follows
// Summary of operation
// (R01) Select backup reference when select is 1
// (R02) Fabric drives reference select to switch over
// (R03) Backup reference same frequency, independent source
// (R04) Reference divider limited to 1 through 63
// (R05) Feedback divider integer and fractional ranges
// (R06) Fraction of 24 bits via modulator
// (R07) External feedback needs output zero looped back
// (R08) Four outputs; third and fourth may cascade
// (R09) Outputs valid only while lock high
// (R10) Outputs low without reference or powered down
// (R11) Lock only after frequency and phase lock
// (R12) Programmable power-of-two lock delay, default 256
// (R13) Power-down resets asynchronously, outputs low
// (R14) Hold power-down until reset and bank ready
// (R15) Oscillator reference ties power-down to reset
// (R16) Per-output enable truth table
// (R17) Stop after second falling divider edge
// (R18) Output enables resynchronised internally
// (R19) Enables within 16 cycles start aligned
// (R20) Divider changes glitch-free while stopped
// (R21) Sync enable starts both reference dividers together
// (R22) Lock drops in power-down, delay restarts
`timescale 1ns/100ps
`default_nettype none
module pllcc_pll
   import pllcc_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   pllcc_if.pll link
);
   // Whole state of the PLL end
   typedef struct packed {
      logic [5:0] rdiv_cnt;       // Reference divider counter
      logic rdiv_run;             // Reference divider started
      logic [11:0] fb_cnt;        // Feedback divider counter
      logic [24:0] feedback_fraction_acc;      // Modulator accumulator
      logic [3:0] lock_phase;     // Frequency then phase lock counter
      logic [15:0] lock_cnt;      // Lock delay counter
      logic lock;                 // Lock indicator
      logic [3:0] en_m1;          // Enable sync stage 1
      logic [3:0] en_m2;          // Enable sync stage 2
      logic [3:0] en_m3;          // Enable sync stage 3
      logic [3:0] en_q;           // Agreed enable
      logic [3:0] run;            // Output running
      logic [3:0] lvl;            // Output level
      logic [3:0][1:0] fall_cnt;  // Falling edges since enable drop
      logic [3:0][7:0] div_cnt;   // Output divider counters
      logic [3:0][7:0] div_val;   // Latched divider values
      logic [3:0] align_cnt;      // Alignment window counter
      logic align_open;           // Alignment window active
      logic [3:0] start_pend;     // Outputs waiting to start
      logic cfg_err;              // Illegal divider setting
   } pllcc_pll_st_t;
   pllcc_pll_st_t st_r;
   pllcc_pll_st_t st_nxt;
   logic ref_ok;          // Selected reference running
   logic ref_tick;        // Post-divided reference pulse
   logic fb_ok;           // Feedback setting legal
   logic [16:0] lock_target; // Lock delay count
   logic [3:0] en_rise;   // Enables newly high
   logic [3:0] tick_in;   // Divider input pulse per output

   // Reference selection and legality checks
   always_comb
   begin
      ref_ok = link.ref_sel ? link.ref_clk_backup_ok : link.ref_clk_primary_ok; // R01
      if (link.feedback_fraction_mode)
      begin
         fb_ok = (link.feedback_integer_part >= PLLCC_FBFRAC_MIN) &&
            (link.feedback_integer_part <= PLLCC_FBFRAC_MAX); // R05
      end
      else
      begin
         fb_ok = ((link.feedback_integer_part >= PLLCC_FBINT_MIN) &&
            (link.feedback_integer_part <= PLLCC_FBINT_GAP_HI)) ||
            (link.feedback_integer_part >= PLLCC_FBINT_UP_MIN); // R05
      end
      lock_target = 17'h00001 << link.lock_delay_exp; // R12
   end

   // Next-state logic
   always_comb
   begin
      st_nxt = st_r;
      ref_tick = 1'b0;
      st_nxt.cfg_err = !fb_ok || (link.ref_div < PLLCC_REFDIV_MIN) ||
         (link.lock_delay_exp < PLLCC_LOCKDLY_MIN); // R04
      // Reference divider starts on own enable or shared sync enable
      if (link.ref_divider_sync_en || link.ref_divider_reg_en)
      begin
         st_nxt.rdiv_run = 1'b1; // R21
      end
      if (st_r.rdiv_run && ref_ok)
      begin
         if (st_r.rdiv_cnt + 6'h01 >= link.ref_div)
         begin
            st_nxt.rdiv_cnt = 6'h00; // R04
            ref_tick = 1'b1;
         end
         else
         begin
            st_nxt.rdiv_cnt = st_r.rdiv_cnt + 6'h01;
         end
      end
      // Feedback divider with fractional modulator carry
      if (ref_tick)
      begin
         st_nxt.feedback_fraction_acc = {1'b0, st_r.feedback_fraction_acc[23:0]} +
            (link.feedback_fraction_mode ? {1'b0, link.feedback_fraction_value} : 25'h0000000); // R06
      end
      if (st_r.fb_cnt >= link.feedback_integer_part + {11'h000, st_r.feedback_fraction_acc[24]})
      begin
         st_nxt.fb_cnt = 12'h000;
      end
      else
      begin
         st_nxt.fb_cnt = st_r.fb_cnt + 12'h001;
      end
      // Lock: frequency and phase settle, then delay count
      if (!ref_ok || st_r.cfg_err || !st_r.rdiv_run)
      begin
         st_nxt.lock_phase = 4'h0;
         st_nxt.lock_cnt = 16'h0000;
         st_nxt.lock = 1'b0; // R11
      end
      else if (ref_tick)
      begin
         if (st_r.lock_phase < PLLCC_LOCK_PHASES)
         begin
            st_nxt.lock_phase = st_r.lock_phase + 4'h1; // R11
         end
         else if ({1'b0, st_r.lock_cnt} + 17'h00001 >= lock_target)
         begin
            st_nxt.lock = 1'b1; // R12
         end
         else
         begin
            st_nxt.lock_cnt = st_r.lock_cnt + 16'h0001; // R12
         end
      end
      // Enable resync through three flops, change on agreement
      st_nxt.en_m1 = link.out_en; // R18
      st_nxt.en_m2 = st_r.en_m1;
      st_nxt.en_m3 = st_r.en_m2;
      st_nxt.en_q = (st_r.en_m2 == st_r.en_m3) ? st_r.en_m3 : st_r.en_q;
      en_rise = st_nxt.en_q & ~st_r.en_q;
      // Alignment window gathers starts within 16 cycles
      st_nxt.start_pend = (st_r.start_pend | en_rise) & st_nxt.en_q;
      if (en_rise != 4'h0 && !st_r.align_open)
      begin
         st_nxt.align_open = 1'b1; // R19
         st_nxt.align_cnt = 4'h0;
      end
      else if (st_r.align_open)
      begin
         if (st_r.align_cnt == PLLCC_ALIGN_WIN)
         begin
            st_nxt.align_open = 1'b0; // R19
         end
         else
         begin
            st_nxt.align_cnt = st_r.align_cnt + 4'h1;
         end
      end
      // Per-output dividers; third feeds fourth when cascaded
      for (int i = 0; i < PLLCC_NUM_OUT; i++)
      begin
         tick_in[i] = st_r.lock;
         if (i == 3 && link.cascade_34)
         begin
            tick_in[i] = st_r.lock && st_r.lvl[2] && (st_r.div_cnt[2] == 8'h00); // R08
         end
         if (st_r.align_open && st_r.align_cnt == PLLCC_ALIGN_WIN && st_r.start_pend[i])
         begin
            st_nxt.run[i] = 1'b1; // R19
            st_nxt.start_pend[i] = 1'b0;
            st_nxt.div_cnt[i] = 8'h00;
            st_nxt.lvl[i] = 1'b0;
            st_nxt.fall_cnt[i] = 2'h0;
         end
         else if (!st_r.run[i])
         begin
            st_nxt.div_val[i] = (link.out_div[i] == 8'h00) ? PLLCC_OUTDIV_RST : link.out_div[i]; // R20
            st_nxt.lvl[i] = 1'b0;
         end
         else if (tick_in[i])
         begin
            if (st_r.div_cnt[i] + 8'h01 >= st_r.div_val[i])
            begin
               st_nxt.div_cnt[i] = 8'h00;
               st_nxt.lvl[i] = !st_r.lvl[i];
               // Count falling edges after enable drop, stop at second
               if (st_r.lvl[i] && !st_r.en_q[i])
               begin
                  st_nxt.fall_cnt[i] = st_r.fall_cnt[i] + 2'h1;
                  if (st_r.fall_cnt[i] == 2'h1)
                  begin
                     st_nxt.run[i] = 1'b0; // R17
                  end
               end
            end
            else
            begin
               st_nxt.div_cnt[i] = st_r.div_cnt[i] + 8'h01;
            end
         end
         if (st_r.en_q[i])
         begin
            st_nxt.fall_cnt[i] = 2'h0;
         end
      end
      // Outputs low without reference; run bits stay set, so outputs resume on relock
      if (!ref_ok)
      begin
         st_nxt.lvl = 4'h0; // R10
      end
   end

   // State register; power-down is an asynchronous reset too
   always_ff @(posedge pclk or negedge presetn or negedge link.pll_sleep_n)
   begin
      if (!presetn || !link.pll_sleep_n)
      begin
         st_r <= '0; // R13 R22
      end
      else
      begin
         st_r <= st_nxt;
      end
   end

   // Outputs gated by power-down, enable and lock
   always_comb
   begin
      link.clk_out = st_r.lvl & st_r.run & {4{st_r.lock}} & {4{link.pll_sleep_n}}; // R16 R09
      link.lock = st_r.lock & link.pll_sleep_n; // R22
      link.cfg_err = st_r.cfg_err;
   end
endmodule
`default_nettype wire

//--- hdl/pllcc_fabric.sv
// Purpose: Fabric user logic that drives the PLL controls from APB registers
// Assumes: APB slave at pclk; reset and bank status arrive as plain inputs
// Notes: Registers: 0x00 control, 0x04 divider, 0x08 fraction, 0x0c status
`timescale 1ns/100ps
`default_nettype none
module pllcc_fabric
   import pllcc_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic fabric_por_n,
   input wire logic io_bank_ready,
   input wire logic osc_ref,
   input wire logic ref_clk_primary_ok,
   input wire logic ref_clk_backup_ok,
   input wire logic [3:0] clk_fb_src,
   output logic [3:0] clk_valid,
   pllcc_if.fabric link
);
   // Whole state of the fabric end
   typedef struct packed {
      logic [31:0] ctrl;   // Control word
      logic [31:0] div;    // Divider word
      logic [23:0] feedback_fraction;   // Fraction word
      logic [31:0] rdata;  // Read data
      logic [2:0] por_s;   // Reset sync
      logic [2:0] bank_s;  // Bank ready sync
      logic ready_ok;      // Reset released, and bank ready unless oscillator reference
   } pllcc_fab_st_t;
   pllcc_fab_st_t st_r;
   pllcc_fab_st_t st_nxt;
   logic wr;  // Write strobe
   logic rd;  // Read strobe

   // Register writes, reads and release tracking
   always_comb
   begin
      st_nxt = st_r;
      wr = psel && penable && pwrite;
      rd = psel && !penable && !pwrite;
      st_nxt.por_s = {st_r.por_s[1:0], fabric_por_n};
      st_nxt.bank_s = {st_r.bank_s[1:0], io_bank_ready};
      if (st_r.por_s[2] == st_r.por_s[1] && st_r.bank_s[2] == st_r.bank_s[1])
      begin
         st_nxt.ready_ok = st_r.por_s[2] && (osc_ref || st_r.bank_s[2]); // R14
      end
      if (wr)
      begin
         case (paddr)
            PLLCC_A_CTRL: st_nxt.ctrl = pwdata;
            PLLCC_A_DIV: st_nxt.div = pwdata;
            PLLCC_A_FEEDBACK_FRACTION: st_nxt.feedback_fraction = pwdata[23:0];
            default: st_nxt.ctrl = st_r.ctrl;
         endcase
      end
      if (rd)
      begin
         case (paddr)
            PLLCC_A_CTRL: st_nxt.rdata = st_r.ctrl;
            PLLCC_A_DIV: st_nxt.rdata = st_r.div;
            PLLCC_A_FEEDBACK_FRACTION: st_nxt.rdata = {8'h00, st_r.feedback_fraction};
            PLLCC_A_STAT: st_nxt.rdata = {28'h0000000, link.clk_out == 4'h0,
               st_r.ready_ok, link.cfg_err, link.lock};
            default: st_nxt.rdata = 32'h00000000;
         endcase
      end
   end

   // State register
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         st_r <= '0;
         st_r.ctrl[15:12] <= PLLCC_LOCKDLY_DEF;
         st_r.div[5:0] <= PLLCC_REFDIV_MIN;
         st_r.div[17:6] <= PLLCC_FBINT_UP_MIN;
      end
      else
      begin
         st_r <= st_nxt;
      end
   end

   // Drive PLL controls from registers
   always_comb
   begin
      prdata = st_r.rdata;
      pready = 1'b1;
      pslverr = 1'b0;
      link.ref_sel = st_r.ctrl[0]; // R02
      link.feedback_fraction_mode = st_r.ctrl[1];
      link.ext_fb_mode = st_r.ctrl[2];
      link.cascade_34 = st_r.ctrl[3];
      link.out_en = st_r.ctrl[7:4];
      link.ref_divider_reg_en = st_r.ctrl[8];
      link.ref_divider_sync_en = st_r.ctrl[9];
      link.lock_delay_exp = st_r.ctrl[15:12];
      link.ref_div = st_r.div[5:0];
      link.feedback_integer_part = st_r.div[17:6];
      link.feedback_fraction_value = st_r.feedback_fraction;
      for (int i = 0; i < PLLCC_NUM_OUT; i++)
      begin
         link.out_div[i] = (st_r.div[18 + 3*i +: 3] == 3'h0) ? PLLCC_OUTDIV_RST :
            {5'h00, st_r.div[18 + 3*i +: 3]};
      end
      link.pll_sleep_n = st_r.ready_ok && st_r.ctrl[10]; // R14 R15
      link.ref_clk_primary_ok = ref_clk_primary_ok; // R03
      link.ref_clk_backup_ok = ref_clk_backup_ok;
      link.feedback_clock_in = link.ext_fb_mode ? link.clk_out[0] : clk_fb_src[0]; // R07
      clk_valid = link.clk_out & {4{link.lock}}; // R09
   end
endmodule
`default_nettype wire

//--- test/pllcc_monitor.sv
// Purpose: Concurrent checks on the signals joining the PLL end and the fabric end
// Assumes: One clock pclk, asynchronous active-low reset presetn
// Notes: Instantiated by the testbench beside the carrier, no bind
`timescale 1ns/100ps
`default_nettype none
module pllcc_monitor
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic ref_sel,
   input wire logic [5:0] ref_div,
   input wire logic [11:0] feedback_integer_part,
   input wire logic feedback_fraction_mode,
   input wire logic cascade_34,
   input wire logic [3:0] lock_delay_exp,
   input wire logic [7:0] out_div [4],
   input wire logic pll_sleep_n,
   input wire logic [3:0] out_en,
   input wire logic ref_clk_primary_ok,
   input wire logic ref_clk_backup_ok,
   input wire logic [3:0] clk_out,
   input wire logic lock,
   input wire logic cfg_err
);
   logic [16:0] awake_cnt; // Cycles since power-down was released
   logic [7:0] stop_cnt; // Cycles output zero has stayed disabled with a divider of 7 or less
   // Divider settings outside the legal ranges
   wire logic bad_cfg = (ref_div == 6'h00) || (lock_delay_exp == 4'h0) || (feedback_fraction_mode ?
      (feedback_integer_part < 12'h014 || feedback_integer_part > 12'h1f4) :
      (feedback_integer_part < 12'h008 || feedback_integer_part == 12'h00b));
   // All outputs enabled together, not cascaded, with equal dividers and power-down released
   wire logic aligned_run = out_en == 4'hf && !cascade_34 && pll_sleep_n &&
      out_div[0] == out_div[1] && out_div[1] == out_div[2] && out_div[2] == out_div[3];
   // Counters that stand in for long repetitions
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         awake_cnt <= 17'h00000;
         stop_cnt <= 8'h00;
      end
      else
      begin
         awake_cnt <= !pll_sleep_n ? 17'h00000 : awake_cnt + {16'h0000, ~&awake_cnt};
         stop_cnt <= (out_en[0] || out_div[0] > 8'h07) ? 8'h00 : stop_cnt + {7'h00, ~&stop_cnt};
      end
   end
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   // Selected reference has been absent for a while
   sequence ref_missing_s;
      (ref_sel ? !ref_clk_backup_ok : !ref_clk_primary_ok) [*8];
   endsequence
   // Everything stopped, then all enables arrive in the same cycle
   sequence start_together_s;
      (out_en == 4'h0 && clk_out == 4'h0) ##1 aligned_run [*8];
   endsequence
   AST_SLEEP_OUT: assert property (!pll_sleep_n |-> clk_out == 4'h0)
      else $error("outputs not low in power-down");
   AST_SLEEP_LOCK: assert property (!pll_sleep_n |-> !lock)
      else $error("lock high in power-down");
   AST_NO_REF: assert property (ref_missing_s |-> clk_out == 4'h0)
      else $error("outputs running without reference");
   AST_LOCK_DELAY: assert property ($rose(lock) |-> awake_cnt >= (17'h1 << lock_delay_exp))
      else $error("lock raised before the lock delay");
   AST_CFG_SET: assert property (bad_cfg [*3] |-> ##[0:4] cfg_err)
      else $error("illegal divider not flagged");
   AST_CFG_CLR: assert property (!bad_cfg [*8] |-> !cfg_err)
      else $error("legal divider flagged");
   AST_STOP: assert property (stop_cnt == 8'hc8 |-> !clk_out[0])
      else $error("output zero still running after stop");
   AST_ALIGN: assert property (start_together_s |-> clk_out == 4'h0 || clk_out == 4'hf)
      else $error("outputs started out of phase");
endmodule
`default_nettype wire

//--- test/pllcc_tb.sv
// Purpose: Self-checking bench joining the PLL end and the fabric end
// Assumes: Fabric registers reached over APB, pready answers each access
// Notes: Lock delay, stop, reference loss and range flags are exercised
`timescale 1ns/100ps
`default_nettype none
module pllcc_tb;
   logic pclk = 1'b0; // Bus and PLL clock
   logic presetn = 1'b0; // Asynchronous reset
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h00000000;
   logic [31:0] prdata;
   logic pready;
   logic fabric_por_n = 1'b1; // Fabric power-on reset negated
   logic io_bank_ready = 1'b0; // Input buffer bank not yet ready
   logic osc_ref = 1'b0; // Reference from an I/O by default
   logic prim_ok = 1'b1; // Primary reference running
   logic back_ok = 1'b1; // Backup reference running
   logic [3:0] clk_valid;
   logic [31:0] q; // Scratch read data
   logic [3:0] seen; // Outputs seen toggling
   int fail_count = 0;
   int checks_done = 0;
   int n; // Wait length in cycles
   logic [31:0] cfg_tab [6][3] = '{'{32'h8700, 32'h300, 32'h2}, '{32'h8700, 32'h33f, 32'h0},
      '{32'h8700, 32'h2c1, 32'h2}, '{32'h8700, 32'h3ffc1, 32'h0},
      '{32'h8702, 32'h4c1, 32'h2}, '{32'h8702, 32'h7d01, 32'h0}};
   pllcc_if link_if();
   always #12.5 pclk = ~pclk;
   pllcc_pll pllcc_pll_i (.pclk(pclk), .presetn(presetn), .link(link_if.pll));
   pllcc_fabric pllcc_fabric_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(), .fabric_por_n(fabric_por_n), .io_bank_ready(io_bank_ready),
      .osc_ref(osc_ref), .ref_clk_primary_ok(prim_ok), .ref_clk_backup_ok(back_ok),
      .clk_fb_src(4'h1), .clk_valid(clk_valid), .link(link_if.fabric));
   pllcc_monitor pllcc_monitor_i (.pclk(pclk), .presetn(presetn), .ref_sel(link_if.ref_sel),
      .ref_div(link_if.ref_div), .feedback_integer_part(link_if.feedback_integer_part),
      .feedback_fraction_mode(link_if.feedback_fraction_mode), .cascade_34(link_if.cascade_34),
      .lock_delay_exp(link_if.lock_delay_exp), .out_div(link_if.out_div),
      .pll_sleep_n(link_if.pll_sleep_n), .out_en(link_if.out_en),
      .ref_clk_primary_ok(link_if.ref_clk_primary_ok),
      .ref_clk_backup_ok(link_if.ref_clk_backup_ok), .clk_out(link_if.clk_out),
      .lock(link_if.lock), .cfg_err(link_if.cfg_err));
   // Compare one value and count it
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp)
      begin
         fail_count++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // One APB transfer: setup, access until pready, then release
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1)
         @(posedge pclk);
      q = prdata;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask
   // Read a register and compare the masked word
   task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
      apb(1'b0, a, 32'h00000000);
      chk(q & m, e);
   endtask
   // Wait, bounded, for lock (sel 0) or the power-down line (sel 1) to reach v
   task automatic wait_for(input int sel, input logic v);
      n = 0;
      while (((sel == 0) ? link_if.lock : link_if.pll_sleep_n) !== v && n < 5000)
      begin
         @(posedge pclk);
         n++;
      end
      chk(n < 5000, 32'h1);
   endtask
   // Collect which outputs toggle, and how often output three does
   task automatic toggles();
      logic [3:0] prev;
      prev = link_if.clk_out;
      seen = 4'h0;
      n = 0;
      repeat (300)
      begin
         @(posedge pclk);
         seen = seen | (prev ^ link_if.clk_out);
         n = n + int'(prev[3] ^ link_if.clk_out[3]);
         prev = link_if.clk_out;
      end
   endtask
   // Print the verdict and end the run
   task automatic print_verdict();
      if (fail_count == 0 && checks_done > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   // Watchdog against a hung wait
   initial
   begin
      repeat (95000) @(posedge pclk);
      fail_count++;
      print_verdict();
   end
   // Main test sequence
   initial
   begin
      repeat (16) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      rd(8'h00, 32'h0000ffff, 32'h00008000);
      rd(8'h04, 32'h0003ffff, 32'h00000301);
      rd(8'h10, 32'hffffffff, 32'h00000000);
      apb(1'b1, 8'h00, 32'h00008700);
      repeat (20) @(posedge pclk);
      chk(link_if.pll_sleep_n, 32'h0);
      chk(link_if.clk_out, 32'h0);
      io_bank_ready <= 1'b1;
      wait_for(1, 1'b1);
      // Sleep, then wake with both, sync only and register only divider enables
      for (int i = 0; i < 3; i++)
      begin
         apb(1'b1, 8'h00, 32'h00000000 | ((3 * i + 1) << 12));
         wait_for(1, 1'b0);
         chk(link_if.lock, 32'h0);
         chk(link_if.clk_out, 32'h0);
         apb(1'b1, 8'h00, 32'h00000400 | (32'h00000300 & ~(32'h00000080 << i)) |
            ((3 * i + 1) << 12));
         wait_for(1, 1'b1);
         wait_for(0, 1'b1);
         chk(n >= (1 << (3 * i + 1)), 32'h1);
         chk(n <= (1 << (3 * i + 1)) + 8, 32'h1);
      end
      osc_ref <= 1'b1;
      io_bank_ready <= 1'b0;
      fabric_por_n <= 1'b0;
      wait_for(1, 1'b0);
      fabric_por_n <= 1'b1;
      wait_for(1, 1'b1);
      apb(1'b1, 8'h00, 32'h000087f0);
      wait_for(0, 1'b1);
      toggles();
      chk(seen, 32'hf);
      chk(link_if.lock, 32'h1);
      chk(clk_valid, link_if.clk_out);
      apb(1'b1, 8'h00, 32'h00008700);
      repeat (200) @(posedge pclk);
      chk(link_if.clk_out, 32'h0);
      rd(8'h0c, 32'h0000000f, 32'h0000000d);
      apb(1'b1, 8'h04, 32'h1b6c0301);
      chk(link_if.out_div[0], 32'h3);
      apb(1'b1, 8'h00, 32'h000087f0);
      toggles();
      chk(seen, 32'hf);
      prim_ok <= 1'b0;
      repeat (20) @(posedge pclk);
      chk(link_if.clk_out, 32'h0);
      apb(1'b1, 8'h00, 32'h000087f1);
      wait_for(0, 1'b1);
      toggles();
      chk(seen, 32'hf);
      apb(1'b1, 8'h00, 32'h000087f9);
      toggles();
      chk(seen, 32'hf);
      chk(n < 40, 32'h1);
      prim_ok <= 1'b1;
      foreach (cfg_tab[i])
      begin
         apb(1'b1, 8'h00, cfg_tab[i][0]);
         apb(1'b1, 8'h04, cfg_tab[i][1]);
         repeat (8) @(posedge pclk);
         rd(8'h0c, 32'h00000002, cfg_tab[i][2]);
      end
      apb(1'b1, 8'h08, 32'hffffffff);
      rd(8'h08, 32'h00ffffff, 32'h00ffffff);
      chk(link_if.feedback_fraction_value, 32'h00ffffff);
      print_verdict();
   end
endmodule
`default_nettype wire
